/* pkg/adcsq_pkg.sv */
// Package: register map, fields, timing and carrier types of the converter sequencer
package adcsq_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [2:0] ADCSQ_OFF_CTRL_A = 3'h0;
	localparam logic [2:0] ADCSQ_OFF_CTRL_B = 3'h1;
	localparam logic [2:0] ADCSQ_OFF_RES_HI = 3'h2;
	localparam logic [2:0] ADCSQ_OFF_RES_LO = 3'h3;
	localparam logic [2:0] ADCSQ_OFF_IRQ_STAT = 3'h4;
	localparam logic [2:0] ADCSQ_OFF_IRQ_MASK = 3'h5;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int ADCSQ_BIT_ON = 0;
	localparam int ADCSQ_BIT_GO = 1;
	localparam int ADCSQ_CHS_LSB = 2;
	localparam int ADCSQ_CCS_LSB = 6;
	localparam int ADCSQ_BIT_POSREF = 4;
	localparam int ADCSQ_BIT_NEGREF = 5;
	localparam int ADCSQ_BIT_JUSTIFY = 7;
	localparam int ADCSQ_BIT_DONE_IRQ = 0;
	localparam logic [7:0] ADCSQ_CTRL_B_MASK = 8'hB0;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ADCSQ_RST_CTRL_A = 8'h00;
	localparam logic [7:0] ADCSQ_RST_CTRL_B = 8'h00;
	localparam logic [7:0] ADCSQ_RST_RES = 8'h00;
	localparam logic [7:0] ADCSQ_RST_IRQ = 8'h00;

	// ---------------------------------------------------------------
	// Clock selection and timing
	// ---------------------------------------------------------------
	localparam logic [1:0] ADCSQ_CCS_DIV2 = 2'h0;
	localparam logic [1:0] ADCSQ_CCS_DIV8 = 2'h1;
	localparam logic [1:0] ADCSQ_CCS_DIV32 = 2'h2;
	localparam logic [1:0] ADCSQ_CCS_RC = 2'h3;
	localparam int ADCSQ_DIV2 = 2;
	localparam int ADCSQ_DIV8 = 8;
	localparam int ADCSQ_DIV32 = 32;
	localparam int ADCSQ_MCLK_KHZ = 20000;
	localparam int ADCSQ_RC_MAX_KHZ = 500;
	localparam int ADCSQ_RC_DIV = (ADCSQ_MCLK_KHZ + ADCSQ_RC_MAX_KHZ - 1) / ADCSQ_RC_MAX_KHZ;
	localparam int ADCSQ_CONV_PERIODS = 11;
	localparam int ADCSQ_ABORT_PERIODS = 2;

	// ---------------------------------------------------------------
	// Input select codes
	// ---------------------------------------------------------------
	localparam logic [3:0] ADCSQ_CHS_LAST_PIN = 4'hD;
	localparam logic [3:0] ADCSQ_CHS_CMP_REF = 4'hE;
	localparam logic [3:0] ADCSQ_CHS_FIXED_REF = 4'hF;

	// ---------------------------------------------------------------
	// Carrier types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} adcsq_bus_type;

	typedef struct packed {
		logic powered;
		logic sample;
		logic [13:0] pin_sel;
		logic cmp_ref_sel;
		logic fixed_ref_sel;
		logic neg_ref_ext;
		logic pos_ref_ext;
	} adcsq_analog_type;

	typedef enum logic [1:0] {
		ADCSQ_IDLE = 2'b00,
		ADCSQ_CONVERT = 2'b01,
		ADCSQ_HOLDOFF = 2'b10
	} adcsq_state_type;

endpackage : adcsq_pkg

/* core/adcsq_bitclk.sv */
// Bit clock enable generator with selectable system divider or RC rate
`timescale 1ns/1ps
module adcsq_bitclk (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [1:0] conv_clock_select,
	// Bit clock enable
	output logic tick
);
	import adcsq_pkg::*;

	logic [5:0] count;
	logic [5:0] next_count;
	logic [5:0] limit;
	logic next_tick;

	always_comb begin
		case (conv_clock_select)
			ADCSQ_CCS_DIV2: limit = 6'(ADCSQ_DIV2 - 1);
			ADCSQ_CCS_DIV8: limit = 6'(ADCSQ_DIV8 - 1);
			ADCSQ_CCS_DIV32: limit = 6'(ADCSQ_DIV32 - 1);
			default: limit = 6'(ADCSQ_RC_DIV - 1);
		endcase
		next_tick = 1'b0;
		if (!run) begin
			next_count = 6'h00;
		end else if (count >= limit) begin
			next_count = 6'h00;
			next_tick = 1'b1;
		end else begin
			next_count = count + 6'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= 6'h00;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

endmodule : adcsq_bitclk

/* core/adcsq_sar.sv */
// Successive-approximation stepper driving the comparator trial word
`timescale 1ns/1ps
module adcsq_sar (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic tick,
	input wire logic cmp_high,
	// Status
	output logic [9:0] trial,
	output logic [9:0] result,
	output logic done
);
	import adcsq_pkg::*;

	logic [3:0] step;
	logic [3:0] next_step;
	logic [9:0] next_trial;
	logic [9:0] next_result;
	logic next_done;
	logic [9:0] bitmask;

	always_comb begin
		next_step = step;
		next_trial = trial;
		next_result = result;
		next_done = 1'b0;
		bitmask = 10'h200 >> step;
		if (abort) begin
			next_step = 4'h0;
		end else if (start) begin
			next_step = 4'h1;
			next_trial = 10'h200;
		end else if (tick && step != 4'h0) begin
			if (step == 4'(ADCSQ_CONV_PERIODS)) begin
				next_step = 4'h0;
				next_result = trial;
				next_done = 1'b1;
			end else begin
				next_step = step + 4'h1;
				if (step <= 4'hA) begin
					if (cmp_high)
						next_trial = trial & ~(10'h200 >> (step - 4'h1));
					if (step < 4'hA)
						next_trial = (cmp_high ? trial & ~(10'h200 >> (step - 4'h1)) : trial)
							| bitmask;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			step <= 4'h0;
			trial <= 10'h000;
			result <= 10'h000;
			done <= 1'b0;
		end else begin
			step <= next_step;
			trial <= next_trial;
			result <= next_result;
			done <= next_done;
		end
	end

endmodule : adcsq_sar

/* core/adcsq_top.sv */
// Converter sequencer: control registers, conversion timing, results and interrupt
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module adcsq_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire adcsq_pkg::adcsq_bus_type bus,
	output logic [7:0] rdata,
	// Converter core
	input wire logic cmp_high_pin,
	output logic [9:0] trial,
	output adcsq_pkg::adcsq_analog_type analog,
	// Interrupt
	output logic irq
);
	import adcsq_pkg::*;

	// ---------------------------------------------------------------
	// Registers and state
	// ---------------------------------------------------------------
	logic [7:0] converter_control_a;
	logic [7:0] converter_control_b;
	logic [7:0] result_high_byte;
	logic [7:0] result_low_byte;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] next_control_a;
	logic [7:0] next_control_b;
	logic [7:0] next_res_hi;
	logic [7:0] next_res_lo;
	logic [7:0] next_irq_status;
	logic [7:0] next_irq_mask;
	logic [7:0] next_rdata;
	logic next_irq;
	adcsq_state_type state;
	adcsq_state_type next_state;
	logic [1:0] holdoff;
	logic [1:0] next_holdoff;
	adcsq_analog_type next_analog;

	// ---------------------------------------------------------------
	// Comparator input
	// ---------------------------------------------------------------
	// Answers the registered trial word on this clock, so no synchroniser;
	// two extra flops would exceed the two-cycle bit period at divide by 2
	logic cmp_sync;

	assign cmp_sync = cmp_high_pin;

	// ---------------------------------------------------------------
	// Decoded controls
	// ---------------------------------------------------------------
	logic converter_on;
	logic go_flag;
	logic [3:0] input_select;
	logic [1:0] conv_clock_select;
	logic justify_select;
	logic wr_a;
	logic go_write_one;
	logic go_write_zero;
	logic start;
	logic abort;
	logic tick;
	logic sar_done;
	logic [9:0] sar_result;
	logic [9:0] sar_trial;
	logic clk_run;

	assign converter_on = converter_control_a[ADCSQ_BIT_ON];
	assign go_flag = converter_control_a[ADCSQ_BIT_GO];
	assign input_select = converter_control_a[ADCSQ_CHS_LSB +: 4];
	assign conv_clock_select = converter_control_a[ADCSQ_CCS_LSB +: 2];
	assign justify_select = converter_control_b[ADCSQ_BIT_JUSTIFY];
	assign wr_a = bus.wr && bus.addr == ADCSQ_OFF_CTRL_A;
	// Start only if already powered before this write
	assign go_write_one = wr_a && bus.wdata[ADCSQ_BIT_GO] && !go_flag && converter_on
		&& bus.wdata[ADCSQ_BIT_ON] && state == ADCSQ_IDLE;
	assign go_write_zero = wr_a && !bus.wdata[ADCSQ_BIT_GO] && state == ADCSQ_CONVERT;
	assign start = go_write_one;
	// Abort on software clear or power down
	assign abort = state == ADCSQ_CONVERT && (go_write_zero || !converter_on);
	assign clk_run = converter_on && state != ADCSQ_IDLE;

	// ---------------------------------------------------------------
	// Bit clock and converter stepper
	// ---------------------------------------------------------------
	adcsq_bitclk u_bitclk (
		.mclk(mclk),
		.rst(rst),
		.run(clk_run),
		.conv_clock_select(conv_clock_select),
		.tick(tick)
	);

	adcsq_sar u_sar (
		.mclk(mclk),
		.rst(rst),
		.start(start),
		.abort(abort),
		.tick(tick),
		.cmp_high(cmp_sync),
		.trial(sar_trial),
		.result(sar_result),
		.done(sar_done)
	);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_holdoff = holdoff;
		case (state)
			ADCSQ_IDLE: begin
				if (start)
					next_state = ADCSQ_CONVERT;
			end
			ADCSQ_CONVERT: begin
				if (abort) begin
					next_state = ADCSQ_HOLDOFF;
					next_holdoff = 2'(ADCSQ_ABORT_PERIODS);
				end else if (sar_done) begin
					next_state = ADCSQ_IDLE;
				end
			end
			ADCSQ_HOLDOFF: begin
				if (!converter_on) begin
					next_state = ADCSQ_IDLE;
				end else if (tick) begin
					next_holdoff = holdoff - 2'h1;
					if (holdoff == 2'h1)
						next_state = ADCSQ_IDLE;
				end
			end
			default: next_state = ADCSQ_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ADCSQ_IDLE;
			holdoff <= 2'h0;
		end else begin
			state <= next_state;
			holdoff <= next_holdoff;
		end
	end

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	always_comb begin
		next_control_a = converter_control_a;
		next_control_b = converter_control_b;
		next_res_hi = result_high_byte;
		next_res_lo = result_low_byte;
		next_irq_status = irq_status;
		next_irq_mask = irq_mask;
		next_rdata = 8'h00;
		if (bus.wr) begin
			case (bus.addr)
				ADCSQ_OFF_CTRL_A: begin
					next_control_a = bus.wdata;
					next_control_a[ADCSQ_BIT_GO] = start
						|| (go_flag && bus.wdata[ADCSQ_BIT_GO]);
				end
				ADCSQ_OFF_CTRL_B: next_control_b = bus.wdata & ADCSQ_CTRL_B_MASK;
				ADCSQ_OFF_RES_HI: next_res_hi = bus.wdata;
				ADCSQ_OFF_RES_LO: next_res_lo = bus.wdata;
				ADCSQ_OFF_IRQ_STAT: next_irq_status = irq_status & ~bus.wdata;
				ADCSQ_OFF_IRQ_MASK: next_irq_mask = bus.wdata;
				default: next_rdata = 8'h00;
			endcase
		end
		if (abort && !go_write_zero)
			next_control_a[ADCSQ_BIT_GO] = 1'b0;
		if (sar_done && state == ADCSQ_CONVERT) begin
			next_control_a[ADCSQ_BIT_GO] = 1'b0;
			next_irq_status[ADCSQ_BIT_DONE_IRQ] = 1'b1;
			if (justify_select) begin
				next_res_hi = {6'h00, sar_result[9:8]};
				next_res_lo = sar_result[7:0];
			end else begin
				next_res_hi = sar_result[9:2];
				next_res_lo = {sar_result[1:0], 6'h00};
			end
		end
		if (bus.rd) begin
			case (bus.addr)
				ADCSQ_OFF_CTRL_A: next_rdata = converter_control_a;
				ADCSQ_OFF_CTRL_B: next_rdata = converter_control_b;
				ADCSQ_OFF_RES_HI: next_rdata = result_high_byte;
				ADCSQ_OFF_RES_LO: next_rdata = result_low_byte;
				ADCSQ_OFF_IRQ_STAT: next_rdata = irq_status;
				ADCSQ_OFF_IRQ_MASK: next_rdata = irq_mask;
				default: next_rdata = 8'h00;
			endcase
		end
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			converter_control_a <= ADCSQ_RST_CTRL_A;
			converter_control_b <= ADCSQ_RST_CTRL_B;
			result_high_byte <= ADCSQ_RST_RES;
			result_low_byte <= ADCSQ_RST_RES;
			irq_status <= ADCSQ_RST_IRQ;
			irq_mask <= ADCSQ_RST_IRQ;
			rdata <= 8'h00;
			irq <= 1'b0;
		end else begin
			converter_control_a <= next_control_a;
			converter_control_b <= next_control_b;
			result_high_byte <= next_res_hi;
			result_low_byte <= next_res_lo;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			rdata <= next_rdata;
			irq <= next_irq;
		end
	end

	// ---------------------------------------------------------------
	// Analog front-end controls
	// ---------------------------------------------------------------
	always_comb begin
		next_analog = '0;
		next_analog.powered = converter_on;
		next_analog.sample = converter_on && state != ADCSQ_CONVERT;
		if (converter_on) begin
			if (input_select <= ADCSQ_CHS_LAST_PIN)
				next_analog.pin_sel = 14'h0001 << input_select;
			next_analog.cmp_ref_sel = input_select == ADCSQ_CHS_CMP_REF;
			next_analog.fixed_ref_sel = input_select == ADCSQ_CHS_FIXED_REF;
			next_analog.neg_ref_ext = converter_control_b[ADCSQ_BIT_NEGREF];
			next_analog.pos_ref_ext = converter_control_b[ADCSQ_BIT_POSREF];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			analog <= '0;
			trial <= 10'h000;
		end else begin
			analog <= next_analog;
			trial <= converter_on ? sar_trial : 10'h000;
		end
	end

endmodule : adcsq_top

/* verif/adcsq_assertions.sv */
// Checker: port-level properties of the converter sequencer
`timescale 1ns/1ps
module adcsq_assertions (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Observed ports
	input wire adcsq_pkg::adcsq_bus_type bus,
	input wire logic [7:0] rdata,
	input wire logic [9:0] trial,
	input wire adcsq_pkg::adcsq_analog_type analog,
	input wire logic irq
);
	import adcsq_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire wa = bus.wr && bus.addr == ADCSQ_OFF_CTRL_A;
	wire wb = bus.wr && bus.addr == ADCSQ_OFF_CTRL_B;
	wire wm = bus.wr && bus.addr == ADCSQ_OFF_IRQ_MASK;
	wire wsm = wm || (bus.wr && bus.addr == ADCSQ_OFF_IRQ_STAT);
	wire [1:0] wref = bus.wdata[5:4];
	// -----------------------------------------
	// Sequences and properties
	// -----------------------------------------
	sequence s_quiet2; (!bus.wr)[*2]; endsequence
	sequence s_ref_wr; wb ##1 !wb; endsequence
	sequence s_mask_off; wm && !bus.wdata[0] ##1 !wm; endsequence
	a_read_idle: assert property (!bus.rd |=> rdata == 8'h00)
		else $error("read data outside a read");
	a_ctrlb_read: assert property (bus.rd && bus.addr == ADCSQ_OFF_CTRL_B
		|=> (rdata & ~ADCSQ_CTRL_B_MASK) == 8'h00) else $error("reserved bits set");
	a_off_zero: assert property (!analog.powered |-> analog == '0 && trial == 10'h000)
		else $error("idle converter active");
	a_input_onehot: assert property (analog.powered
		|-> $onehot({analog.pin_sel, analog.cmp_ref_sel, analog.fixed_ref_sel}))
		else $error("input select not one-hot");
	a_off_follows: assert property (wa && !bus.wdata[0] |-> ##[1:2] !analog.powered)
		else $error("converter not switched off");
	a_refs_follow: assert property (s_ref_wr |=> !analog.powered
		|| {analog.neg_ref_ext, analog.pos_ref_ext} == $past(wref, 2))
		else $error("reference select mismatch");
	a_mask_quiet: assert property (s_mask_off |=> !irq)
		else $error("masked interrupt raised");
	a_irq_fall: assert property ($fell(irq) |-> $past(wsm) || $past(wsm, 2))
		else $error("interrupt dropped without software");
	a_power_first: assert property (wa && bus.wdata[1:0] == 2'b11
		&& !analog.powered && !$past(bus.wr) |=> (s_quiet2 |-> ##1 analog.sample))
		else $error("start taken with power-up");
endmodule : adcsq_assertions

bind adcsq_top adcsq_assertions chk_u (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
	.trial(trial), .analog(analog), .irq(irq));

/* verif/adcsq_core_model.sv */
// Partner model: analog input multiplexer and comparator
`timescale 1ns/1ps
module adcsq_core_model (
	// Clock
	input wire logic mclk,
	// Converter side
	input wire logic [9:0] trial,
	input wire adcsq_pkg::adcsq_analog_type analog,
	output logic cmp_high
);
	import adcsq_pkg::*;
	logic [9:0] vin;
	logic last = 1'b0;
	// -----------------------------------------
	// Selected input level
	// -----------------------------------------
	always_comb begin
		vin = 10'h000;
		for (int i = 0; i < 14; i++) begin
			if (analog.pin_sel[i]) begin
				vin = {i[3:0], 6'h2D};
			end
		end
		if (analog.cmp_ref_sel) begin
			vin = 10'h3C1;
		end
		if (analog.fixed_ref_sel) begin
			vin = 10'h0AA;
		end
	end
	// Unpowered comparator output does not hold
	always_ff @(posedge mclk) begin
		last <= cmp_high;
	end
	assign cmp_high = analog.powered ? (trial > vin) : ~last;
endmodule : adcsq_core_model

/* verif/tb_adcsq_top.sv */
// Testbench: register-level tests of the converter sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error at %0t: got %h exp %h", $time, g, e); end end
module tb_adcsq_top;
	import adcsq_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	adcsq_bus_type bus = '0;
	logic [7:0] rdata;
	logic cmp_high;
	logic [9:0] trial;
	adcsq_analog_type analog;
	logic irq;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [7:0] d;
	adcsq_top dut_u (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
		.cmp_high_pin(cmp_high), .trial(trial), .analog(analog), .irq(irq));
	adcsq_core_model core_u (.mclk(mclk), .trial(trial), .analog(analog), .cmp_high(cmp_high));
	initial begin
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
	end
	// -----------------------------------------
	// Bus tasks
	// -----------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk);
		bus <= {a, v, 2'b10};
		@(posedge mclk);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic [2:0] a);
		@(posedge mclk);
		bus <= {a, 8'h00, 2'b01};
		@(posedge mclk);
		bus <= '0;
		@(negedge mclk);
		d = rdata;
	endtask : rd
	task automatic wrap_up;
		$display("Checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// One conversion with clock select i, input 12+i, justify and refs from i
	task automatic convert(input int i);
		int t0, n, w;
		logic [1:0] k;
		logic [3:0] c;
		logic [9:0] v;
		logic j;
		k = i[1:0];
		c = 4'hC + 4'(i);
		j = i[0];
		n = (k == 2'h0) ? 2 : (k == 2'h1) ? 8 : (k == 2'h2) ? 32 : 40;
		v = (c == 4'hE) ? 10'h3C1 : (c == 4'hF) ? 10'h0AA : {c, 6'h2D};
		wr(ADCSQ_OFF_IRQ_MASK, {7'h00, !i[1]});
		wr(ADCSQ_OFF_CTRL_B, {j, 1'b0, k, 4'h0});
		wr(ADCSQ_OFF_CTRL_A, {k, c, 2'b01});
		rd(ADCSQ_OFF_CTRL_B);
		`CHK({analog.powered, analog.neg_ref_ext, analog.pos_ref_ext}, {1'b1, k})
		repeat (100) @(posedge mclk);
		wr(ADCSQ_OFF_CTRL_A, {k, c, 2'b11});
		t0 = cyc;
		rd(ADCSQ_OFF_CTRL_A);
		`CHK(d, {k, c, 2'b11})
		w = 0;
		while (d[1] && w < 1000) begin
			rd(ADCSQ_OFF_CTRL_A);
			w++;
		end
		`CHK(d, {k, c, 2'b01})
		`CHK(cyc - t0 >= 11 * n && cyc - t0 <= 12 * n + 8, 1'b1)
		rd(ADCSQ_OFF_RES_HI);
		`CHK(j ? d & 8'h03 : d, j ? {6'h00, v[9:8]} : v[9:2])
		rd(ADCSQ_OFF_RES_LO);
		`CHK(j ? d : d & 8'hC0, j ? v[7:0] : {v[1:0], 6'h00})
		rd(ADCSQ_OFF_IRQ_STAT);
		`CHK({d[0], irq}, {1'b1, !i[1]})
		wr(ADCSQ_OFF_IRQ_STAT, 8'h01);
		rd(ADCSQ_OFF_IRQ_STAT);
		`CHK({d[0], irq}, 2'b00)
		$display("conversion test %0d done", i);
	endtask : convert
	// -----------------------------------------
	// Test sequence
	// -----------------------------------------
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		wr(3'h7, 8'hFF);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a));
			`CHK(d, 8'h00)
		end
		`CHK(analog, 20'h00000)
		wr(ADCSQ_OFF_CTRL_B, 8'hFF);
		rd(ADCSQ_OFF_CTRL_B);
		`CHK(d, 8'hB0)
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			convert(i);
		end
		wr(ADCSQ_OFF_CTRL_A, 8'hC3);
		repeat (20) @(posedge mclk);
		wr(ADCSQ_OFF_CTRL_A, 8'hC1);
		wr(ADCSQ_OFF_CTRL_A, 8'hC3);
		rd(ADCSQ_OFF_CTRL_A);
		`CHK(d, 8'hC1)
		rd(ADCSQ_OFF_RES_LO);
		`CHK(d, 8'hAA)
		rd(ADCSQ_OFF_IRQ_STAT);
		`CHK(d[0], 1'b0)
		repeat (120) @(posedge mclk);
		wr(ADCSQ_OFF_CTRL_A, 8'hC3);
		rd(ADCSQ_OFF_CTRL_A);
		`CHK(d, 8'hC3)
		wr(ADCSQ_OFF_CTRL_A, 8'h00);
		rd(ADCSQ_OFF_CTRL_A);
		`CHK({d, analog}, 28'h0000000)
		$display("abort test done");
		wr(ADCSQ_OFF_CTRL_A, 8'h03);
		repeat (3) @(posedge mclk);
		rd(ADCSQ_OFF_CTRL_A);
		`CHK({d, analog.sample}, 9'h003)
		$display("power-up start test done");
		wrap_up();
	end
	initial begin
		#2000000;
		error_cnt++;
		wrap_up();
	end
endmodule : tb_adcsq_top
